//--- hdl/mrcs_core.sv
// Function
// - Bit four picks 1650 or 2100/2225 detection.
// - Bit five high syncs transmit clocks terminal.
// - With bit five high, an idle terminal clock lets transmit clocks free-run.
// - Bit five low syncs transmit to receive.
// - Bit six low gives PSTN thresholds.
// - Bit six high gives leased-line thresholds.
// - Bit seven selects answer or originate channel.
// - Second-byte bit five enables the descrambler.
// - Enabled descrambler multiplies by scrambler polynomial.
// - Disabled descrambler passes data unchanged.
// - Second-byte bit seven selects 600 or 1200.
// - Transmit status first-byte bit0 is zero.
// - Receive status first-byte bit0 is one.
// - Pre-descrambler data in bits one to four.
// - Unused data positions read as one.
// - Mailbox exchanges happen six hundred per second.
// - Status bit one holds earliest symbol bit.
// - Low nibble selects off, standard or tones.
// - Third-byte bit seven low while tone detected in tone mode.
`timescale 1ns/10ps
`default_nettype none
module mrcs_core #(
  parameter int EXCH_PERIOD = mrcs_pkg::EXCH_CYCLES,
  parameter int TERM_IDLE = mrcs_pkg::TERM_IDLE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_mbx_wr,
  input wire logic [7:0] i_mbx_wdata,
  input wire logic i_mbx_rd,
  input wire logic i_mbx_rd_rx,
  output logic [7:0] o_mbx_rdata,
  output logic o_exchange,
  output logic o_rx_stat_ready,
  input wire logic i_sym_valid,
  input wire mrcs_pkg::mrcs_sym_t i_sym,
  output logic o_sym_ready,
  input wire logic i_tone_det,
  input wire logic i_terminal_tx_clock_in,
  input wire logic i_rx_clock_ref,
  output logic o_tx_sync_strobe,
  output logic o_tx_free_run,
  output logic o_rx_enable,
  output logic [3:0] o_rx_mode,
  output logic o_detect_1650,
  output logic o_originate,
  output logic [7:0] o_cd_on_level,
  output logic [7:0] o_cd_off_level,
  output logic o_rate_600,
  output logic o_descr_en
);
  import mrcs_pkg::*;

  logic [1:0] wr_idx_r;
  logic [15:0] wr_hold_r;
  logic [23:0] cmd_word_r;
  logic [1:0] rd_idx_r;
  logic [7:0] rdata_r;
  logic [23:0] rx_stat_r;
  logic stat_pend_r;
  logic [EXCH_CNT_W-1:0] exch_cnt_r;
  logic [IDLE_CNT_W-1:0] idle_cnt_r;
  logic term_prev_r;
  logic rxc_prev_r;
  logic [DSCR_LEN-1:0] dscr_r;
  logic [DSCR_LEN-1:0] dscr_nxt;
  logic [3:0] post_bits;

  // Command decode.
  mrcs_cmd_t cmd;
  assign cmd.mode = cmd_word_r[3:0];
  assign cmd.tone_1650 = cmd_word_r[B1_TONE];
  assign cmd.tx_sync_term = cmd_word_r[B1_TXSYNC];
  assign cmd.cd_leased = cmd_word_r[B1_CDLVL];
  assign cmd.originate = cmd_word_r[B1_ORIG];
  assign cmd.descr_en = cmd_word_r[8 + B2_DESCR];
  assign cmd.rate_600 = cmd_word_r[8 + B2_RATE];

  wire last_byte = i_mbx_wr && (wr_idx_r == 2'h2);
  wire [23:0] cmd_in = {i_mbx_wdata, wr_hold_r};
  // Only words marked as receive commands are taken.
  wire cmd_take = last_byte && cmd_in[16 + B3_RX];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_idx_r <= 2'h0;
      wr_hold_r <= 16'h0000;
      cmd_word_r <= CMD_RESET;
    end else if (i_mbx_wr) begin
      wr_idx_r <= last_byte ? 2'h0 : wr_idx_r + 2'h1;
      if (wr_idx_r == 2'h0) wr_hold_r[7:0] <= i_mbx_wdata;
      if (wr_idx_r == 2'h1) wr_hold_r[15:8] <= i_mbx_wdata;
      // Reserved bits are stored as written, never interpreted.
      if (cmd_take) cmd_word_r <= cmd_in;
    end
  end

  // Receiver on for any nonzero mode.
  assign o_rx_enable = (cmd.mode != MODE_OFF);
  assign o_rx_mode = cmd.mode;
  assign o_detect_1650 = cmd.tone_1650;
  assign o_originate = cmd.originate;
  assign o_cd_on_level = cmd.cd_leased ? CD_LL_ON : CD_PSTN_ON;
  assign o_cd_off_level = cmd.cd_leased ? CD_LL_OFF : CD_PSTN_OFF;
  assign o_rate_600 = cmd.rate_600;
  assign o_descr_en = cmd.descr_en;

  // Transmit clock synchronisation source.
  wire term_edge = i_terminal_tx_clock_in && !term_prev_r;
  wire rxc_edge = i_rx_clock_ref && !rxc_prev_r;
  wire term_idle = (idle_cnt_r == IDLE_CNT_W'(TERM_IDLE));
  mrcs_tsrc_t tsrc;
  // Source chosen by bit five and terminal activity.
  // An edge that arrives while idle ends the idle state at once, so the first terminal edge is not lost.
  assign tsrc = !cmd.tx_sync_term ? TSRC_RX : ((term_idle && !term_edge) ? TSRC_FREE : TSRC_TERM);
  assign o_tx_free_run = (tsrc == TSRC_FREE);

  always_comb begin
    unique case (tsrc)
      TSRC_RX: o_tx_sync_strobe = rxc_edge;
      TSRC_TERM: o_tx_sync_strobe = term_edge;
      TSRC_FREE: o_tx_sync_strobe = 1'b0;
    endcase
  end

  // The idle timer saturates so a dead terminal clock stays detected.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      term_prev_r <= 1'b0;
      rxc_prev_r <= 1'b0;
      idle_cnt_r <= IDLE_CNT_W'(TERM_IDLE);
    end else begin
      term_prev_r <= i_terminal_tx_clock_in;
      rxc_prev_r <= i_rx_clock_ref;
      if (term_edge) idle_cnt_r <= '0;
      else if (!term_idle) idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  wire exch_tick = (exch_cnt_r == EXCH_CNT_W'(EXCH_PERIOD - 1));
  assign o_exchange = exch_tick;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) exch_cnt_r <= '0;
    else exch_cnt_r <= exch_tick ? '0 : exch_cnt_r + 1'b1;
  end

  // Symbols wait in the buffer while the previous status is still unread.
  wire buf_valid;
  mrcs_sym_t buf_sym;
  wire stat_load = exch_tick && !stat_pend_r;
  mrcs_buf2 #(
    .WIDTH(4),
    .DEPTH(2)
  ) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(i_sym_valid),
    .i_in_data(i_sym),
    .o_in_ready(o_sym_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_sym),
    .i_out_ready(stat_load)
  );

  // Bits per symbol from mode and rate.
  wire qam = (cmd.mode == MODE_V22BIS);
  wire dpsk = (cmd.mode == MODE_V22) || (cmd.mode == MODE_B212);
  wire [2:0] nbits = qam ? NB_2400 : (dpsk ? (cmd.rate_600 ? NB_600 : NB_1200) : NB_NONE);
  wire [2:0] use_bits = buf_valid ? nbits : NB_NONE;

  always_comb begin
    dscr_nxt = dscr_r;
    post_bits = 4'hF;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < use_bits) begin
        post_bits[i] = cmd.descr_en ?
          (buf_sym.bits[i] ^ dscr_nxt[DSCR_TAP_A-1] ^ dscr_nxt[DSCR_TAP_B-1]) : buf_sym.bits[i];
        dscr_nxt = {dscr_nxt[DSCR_LEN-2:0], buf_sym.bits[i]};
      end
    end
  end

  wire [3:0] keep = 4'hF >> (3'h4 - use_bits);
  wire [3:0] pre_bits = (buf_sym.bits & keep) | ~keep;
  // Answer tone flag, active low in tone mode only.
  wire tone_bit = (cmd.mode == MODE_TONE) ? !i_tone_det : 1'b1;
  wire [23:0] rx_stat_nxt = {tone_bit, 2'b11, post_bits, 1'b0, 8'h00,
                             3'b000, pre_bits, ST_RX_ID};
  wire [23:0] tx_stat = {23'h000000, ST_TX_ID};

  wire [23:0] rd_word = i_mbx_rd_rx ? rx_stat_r : tx_stat;
  wire [7:0] rd_byte = rd_word[8 * rd_idx_r +: 8];
  wire rx_done = i_mbx_rd && i_mbx_rd_rx && (rd_idx_r == 2'h2);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_stat_r <= RX_STAT_RESET;
      dscr_r <= '0;
      stat_pend_r <= 1'b0;
    end else begin
      if (stat_load) begin
        rx_stat_r <= rx_stat_nxt;
        dscr_r <= dscr_nxt;
      end
      if (stat_load) stat_pend_r <= 1'b1;
      else if (rx_done) stat_pend_r <= 1'b0;
    end
  end
  assign o_rx_stat_ready = stat_pend_r;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_idx_r <= 2'h0;
      rdata_r <= 8'h00;
    end else if (i_mbx_rd) begin
      rd_idx_r <= (rd_idx_r == 2'h2) ? 2'h0 : rd_idx_r + 2'h1;
      rdata_r <= rd_byte;
    end
  end
  assign o_mbx_rdata = rdata_r;

  // Checks.
  a_cmd_atomic: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $changed(cmd_word_r) |-> $past(cmd_take))
    else $error("command changed without a full word");
  a_tone_choice: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_detect_1650 == cmd_word_r[4])
    else $error("answer tone choice wrong");
  a_sync_rx: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!cmd_word_r[5] && rxc_edge) |-> o_tx_sync_strobe && !o_tx_free_run)
    else $error("transmit clocks not tied to receive");
  a_sync_term: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (cmd_word_r[5] && term_edge) |=> !o_tx_free_run)
    else $error("terminal clock not followed");
  a_free_run: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_tx_free_run |-> cmd_word_r[5] && !o_tx_sync_strobe && idle_cnt_r == IDLE_CNT_W'(TERM_IDLE))
    else $error("free-run entered wrongly");
  a_cd_levels: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    cmd_word_r[6] ? (o_cd_on_level == 8'h21 && o_cd_off_level == 8'h26)
                  : (o_cd_on_level == 8'h2B && o_cd_off_level == 8'h30))
    else $error("carrier detect levels wrong");
  a_stat_ids: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_mbx_rd && rd_idx_r == 2'h0 |=> o_mbx_rdata[0] == $past(i_mbx_rd_rx))
    else $error("status type bit wrong");
  a_fill_ones: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    stat_load && nbits == NB_600 && buf_valid |=> rx_stat_r[4:2] == 3'b111 && rx_stat_r[20:18] == 3'b111)
    else $error("unused data bits not one");
  a_bypass: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    stat_load && !cmd.descr_en |=> rx_stat_r[20:17] == rx_stat_r[4:1])
    else $error("bypass altered data");
  a_tone_stat: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    stat_load && cmd.mode == MODE_TONE |=> rx_stat_r[23] == !$past(i_tone_det))
    else $error("answer tone status wrong");
  a_exch_rate: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_exchange |=> !o_exchange && exch_cnt_r == '0)
    else $error("exchange spacing wrong");
  a_term_strobe: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (cmd_word_r[5] && term_edge) |-> o_tx_sync_strobe)
    else $error("terminal edge did not resync");
  a_channel_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_originate == cmd_word_r[7])
    else $error("channel choice wrong");
  a_descr_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_descr_en == cmd_word_r[13])
    else $error("descrambler enable wrong");
  a_rate_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_rate_600 == cmd_word_r[15])
    else $error("rate choice wrong");
  a_mode_enable: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_rx_enable == (cmd_word_r[3:0] != 4'h0))
    else $error("receiver enable wrong");
  a_cmd_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_mbx_wr && wr_idx_r != 2'h2) |=> $stable(cmd_word_r))
    else $error("command changed before the third byte");
  a_tx_type: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_mbx_rd && !i_mbx_rd_rx && rd_idx_r == 2'h0) |=> !o_mbx_rdata[0])
    else $error("transmit status type bit wrong");
  a_rx_type: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    stat_load |=> rx_stat_r[0] && !rx_stat_r[16])
    else $error("receive status type bit wrong");
  a_data_order: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (stat_load && buf_valid && nbits == NB_2400) |=> rx_stat_r[4:1] == $past(buf_sym.bits))
    else $error("data bit order wrong");
  a_descr_mult: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (stat_load && buf_valid && cmd.descr_en && nbits != NB_NONE) |=>
      rx_stat_r[17] == ($past(buf_sym.bits[0]) ^ $past(dscr_r[DSCR_TAP_A-1]) ^ $past(dscr_r[DSCR_TAP_B-1])))
    else $error("descrambler output wrong");
  a_pend_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (o_exchange && o_rx_stat_ready) |=> $stable(rx_stat_r))
    else $error("pending status overwritten");
endmodule
`default_nettype wire

//--- include/mrcs_pkg.sv
package mrcs_pkg;
  // Clock and mailbox exchange timing.
  localparam int CLK_HZ = 40_000_000;
  localparam int EXCH_RATE_HZ = 600;
  localparam int EXCH_CYCLES = CLK_HZ / EXCH_RATE_HZ;
  localparam int TERM_IDLE_US = 1000;
  localparam int TERM_IDLE_CYCLES = (CLK_HZ / 1_000_000) * TERM_IDLE_US;
  localparam int EXCH_CNT_W = 17;
  localparam int IDLE_CNT_W = 17;

  // Receive mode field codes.
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_V22BIS = 4'h1;
  localparam logic [3:0] MODE_V22 = 4'h2;
  localparam logic [3:0] MODE_B212 = 4'h3;
  localparam logic [3:0] MODE_TONE = 4'h7;

  // Field positions in the three command bytes.
  localparam int B1_TONE = 4;
  localparam int B1_TXSYNC = 5;
  localparam int B1_CDLVL = 6;
  localparam int B1_ORIG = 7;
  localparam int B2_DESCR = 5;
  localparam int B2_RATE = 7;
  localparam int B3_RX = 0;

  // Status word fields.
  localparam int ST_DATA_LO = 1;
  localparam int ST_TONE = 7;
  localparam logic ST_TX_ID = 1'b0;
  localparam logic ST_RX_ID = 1'b1;
  localparam logic [23:0] CMD_RESET = 24'h000000;
  localparam logic [23:0] RX_STAT_RESET = 24'hFE001F;

  // Carrier detect on and off levels, magnitudes of negative dBm.
  localparam logic [7:0] CD_PSTN_ON = 8'h2B;
  localparam logic [7:0] CD_PSTN_OFF = 8'h30;
  localparam logic [7:0] CD_LL_ON = 8'h21;
  localparam logic [7:0] CD_LL_OFF = 8'h26;

  // Bits per symbol.
  localparam logic [2:0] NB_2400 = 3'h4;
  localparam logic [2:0] NB_1200 = 3'h2;
  localparam logic [2:0] NB_600 = 3'h1;
  localparam logic [2:0] NB_NONE = 3'h0;

  // Self-synchronising descrambler, taps counted from the newest bit.
  localparam int DSCR_LEN = 17;
  localparam int DSCR_TAP_A = 14;
  localparam int DSCR_TAP_B = 17;

  typedef struct packed {
    logic rate_600;
    logic descr_en;
    logic originate;
    logic cd_leased;
    logic tx_sync_term;
    logic tone_1650;
    logic [3:0] mode;
  } mrcs_cmd_t;

  typedef struct packed {
    logic [3:0] bits;
  } mrcs_sym_t;

  typedef enum logic [1:0] {
    TSRC_RX,
    TSRC_TERM,
    TSRC_FREE
  } mrcs_tsrc_t;
endpackage

//--- hdl/mrcs_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module mrcs_buf2 #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  wire [PW-1:0] wr_ptr_inc = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
  wire [PW-1:0] rd_ptr_inc = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

  assign o_in_ready = (count_r != (PW + 1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_inc;
      if (pop) rd_ptr_r <= rd_ptr_inc;
      count_r <= count_r + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) mem_r[g] <= '0;
        else if (push && wr_ptr_r == PW'(g)) mem_r[g] <= i_in_data;
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- test/mrcs_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mrcs_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd,
  output logic o_rd_rx
);
  initial begin
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
    o_rd_rx = 1'b0;
  end

  // Reserved bits cleared, receive marker set.
  function automatic logic [23:0] cmd_word(input logic [3:0] mode, input logic tone, input logic sync,
      input logic cd, input logic orig, input logic descr, input logic rate);
    return {8'h01, rate, 1'b0, descr, 5'h00, orig, cd, sync, tone, mode};
  endfunction

  task automatic wr_word(input logic [23:0] w);
    for (int i = 0; i < 3; i++) begin
      @(posedge i_ref_clk);
      #2;
      o_wr = 1'b1;
      o_wdata = w[8*i +: 8];
    end
    @(posedge i_ref_clk);
    #2;
    o_wr = 1'b0;
    // The released bus shows the inverse, so a stale byte is never taken for a fresh one.
    o_wdata = ~o_wdata;
  endtask

  task automatic rd_word(input logic rx, output logic [23:0] w);
    @(posedge i_ref_clk);
    #2;
    o_rd = 1'b1;
    o_rd_rx = rx;
    for (int i = 0; i < 3; i++) begin
      @(posedge i_ref_clk);
      #2;
      w[8*i +: 8] = i_rdata;
      if (i == 2) begin
        o_rd = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- test/modem_rx_command_status_words_tb.sv
`timescale 1ns/10ps
`default_nettype none
module modem_rx_command_status_words_tb;
  import mrcs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic sym_valid = 1'b0;
  logic tone_det = 1'b0;
  logic term_clk = 1'b0;
  logic rx_clk = 1'b0;
  logic mbx_wr, mbx_rd, mbx_rd_rx, exchange, stat_ready, sym_ready, strobe, free_run;
  logic rx_en, det_1650, orig, rate_600, descr_en;
  logic [7:0] mbx_wdata, mbx_rdata, cd_on, cd_off;
  logic [3:0] rx_mode;
  logic [23:0] w;
  mrcs_sym_t sym = '0;
  int n_errors = 0;
  int cmp_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  mrcs_core #(.EXCH_PERIOD(40), .TERM_IDLE(20)) dut_u (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_mbx_wr(mbx_wr), .i_mbx_wdata(mbx_wdata),
    .i_mbx_rd(mbx_rd), .i_mbx_rd_rx(mbx_rd_rx), .o_mbx_rdata(mbx_rdata), .o_exchange(exchange),
    .o_rx_stat_ready(stat_ready), .i_sym_valid(sym_valid), .i_sym(sym), .o_sym_ready(sym_ready),
    .i_tone_det(tone_det), .i_terminal_tx_clock_in(term_clk), .i_rx_clock_ref(rx_clk),
    .o_tx_sync_strobe(strobe), .o_tx_free_run(free_run), .o_rx_enable(rx_en), .o_rx_mode(rx_mode),
    .o_detect_1650(det_1650), .o_originate(orig), .o_cd_on_level(cd_on), .o_cd_off_level(cd_off),
    .o_rate_600(rate_600), .o_descr_en(descr_en));

  mrcs_cpu_model cpu_u (.i_ref_clk(ref_clk), .i_rdata(mbx_rdata), .o_wr(mbx_wr), .o_wdata(mbx_wdata),
    .o_rd(mbx_rd), .o_rd_rx(mbx_rd_rx));

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #2;
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (stat_ready !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    chk({23'h0, stat_ready}, 24'h1);
  endtask

  task automatic push(input logic [3:0] s);
    logic ok;
    tick(1);
    sym_valid = 1'b1;
    sym.bits = s;
    ok = 1'b0;
    for (int k = 0; k < 100 && !ok; k++) begin
      ok = (sym_ready === 1'b1);
      tick(1);
    end
    sym_valid = 1'b0;
    sym.bits = ~s;
    chk({23'h0, ok}, 24'h1);
  endtask

  task automatic t_exch();
    logic [23:0] n;
    n = 0;
    for (int k = 0; k < 100 && exchange !== 1'b1; k++) begin
      tick(1);
    end
    do begin
      tick(1);
      n++;
    end while (exchange !== 1'b1 && n < 100);
    chk(n, 24'd40);
  endtask

  task automatic t_decode();
    logic [1:0] j;
    logic [23:0] c;
    for (int i = 0; i < 5; i++) begin
      j = (i > 3) ? 2'h3 : i[1:0];
      c = cpu_u.cmd_word({2'h0, j}, j[0], 1'b0, j[1], !j[0], j[0] ^ j[1], !j[1]);
      // The last word lacks its receive marker and must leave every output alone.
      if (i == 4) begin
        c = cpu_u.cmd_word(4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1) & 24'hFEFFFF;
      end
      cpu_u.wr_word(c);
      chk({rx_en, rx_mode, det_1650, orig, rate_600, descr_en}, {j != 0, 2'h0, j, j[0], !j[0], !j[1], j[0] ^ j[1]});
      chk({cd_on, cd_off}, j[1] ? {CD_LL_ON, CD_LL_OFF} : {CD_PSTN_ON, CD_PSTN_OFF});
    end
  endtask

  task automatic t_txstat();
    cpu_u.rd_word(1'b0, w);
    chk({23'h0, w[0]}, 24'h0);
  endtask

  task automatic t_sync(input logic sel);
    logic [23:0] cnt;
    cnt = 0;
    cpu_u.wr_word(cpu_u.cmd_word(4'h1, 1'b0, sel, 1'b0, 1'b0, 1'b0, 1'b0));
    for (int k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      #2;
      term_clk = (k < 16) ? (sel ? k[1] : k[0]) : 1'b0;
      rx_clk = (k < 16) ? (sel ? k[0] : k[1]) : 1'b0;
      #1;
      cnt = cnt + {23'h0, strobe === 1'b1};
    end
    chk(cnt, 24'd4);
    chk({23'h0, free_run}, 24'h0);
    if (sel) begin
      tick(30);
      chk({23'h0, free_run}, 24'h1);
    end
  endtask

  task automatic t_fill();
    cpu_u.wr_word(cpu_u.cmd_word(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_ready();
    push(4'h3);
    push(4'h9);
    chk({23'h0, sym_ready}, 24'h0);
    cpu_u.rd_word(1'b1, w);
    wait_ready();
    cpu_u.rd_word(1'b1, w);
    chk(w, 24'hE60007);
    wait_ready();
    cpu_u.rd_word(1'b1, w);
    chk(w[7:0], 8'h13);
    wait_ready();
    cpu_u.rd_word(1'b1, w);
    chk(w[7:0], 8'h1F);
  endtask

  task automatic t_sym(input logic [3:0] mode, input logic rate, input logic tone, input logic [7:0] e0,
      input logic [7:0] e2);
    tone_det = tone;
    cpu_u.wr_word(cpu_u.cmd_word(mode, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rate));
    wait_ready();
    push(4'h5);
    cpu_u.rd_word(1'b1, w);
    wait_ready();
    cpu_u.rd_word(1'b1, w);
    chk({w[23:16], w[7:0]}, {e2, e0});
  endtask

  // A reset here also clears the descrambler history, so the expected taps start from zeros.
  task automatic t_descr();
    tick(1);
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    chk({rx_en, stat_ready, free_run, cd_on}, {3'h0, CD_PSTN_ON});
    cpu_u.rd_word(1'b1, w);
    chk(w, 24'hFE001F);
    cpu_u.wr_word(cpu_u.cmd_word(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    for (int i = 0; i < 5; i++) begin
      wait_ready();
      push(4'hF);
      cpu_u.rd_word(1'b1, w);
      wait_ready();
      cpu_u.rd_word(1'b1, w);
      chk(w[4:1], 4'hF);
      if (i == 3) begin
        chk(w[20:17], 4'h3);
      end
      if (i == 4) begin
        chk(w[20:17], 4'hE);
      end
    end
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    t_exch();
    t_decode();
    t_txstat();
    t_sync(1'b1);
    t_sync(1'b0);
    t_fill();
    t_sym(4'h2, 1'b0, 1'b0, 8'h1B, 8'hFA);
    t_sym(4'h3, 1'b0, 1'b0, 8'h1B, 8'hFA);
    t_sym(4'h2, 1'b1, 1'b0, 8'h1F, 8'hFE);
    t_sym(4'h7, 1'b0, 1'b1, 8'h1F, 8'h7E);
    t_sym(4'h7, 1'b0, 1'b0, 8'h1F, 8'hFE);
    t_descr();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
